// File: rtl/sbt_tap.sv
// Overview of operation
// - code 000 captures the pin ring and drives the preloaded cells onto the pins.
// - code 001 captures the fixed identification value and shifts it between tdi and tdo.
// - code 010 captures the pins, selects the scan chain and forces the output bus to high-Z.
// - code 100 captures the pins and selects the scan chain without touching memory use.
// - code 111 selects the one-bit bypass register.
// - identification bits 31:29 hold revision and 28:12 device type, both fixed.
// - identification bits 11:1 hold a fixed manufacturer code.
// - identification bit 0 is always 1.
// - the chain has 109 cells, 0 to 107 on pins and 108 internal.
// - under code 000 updated cell 108 enables the output bus when 1, high-Z when 0; reset 0.
// - five test clock rises with tms high reach reset and load the identification code.
// - capture of the instruction register loads 01 into its two low bits.
// - tdi is sampled on test clock rise and tdo changes on test clock fall.
`timescale 1ns/1ps
`include "sbt_defs.svh"
module sbt_tap (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output logic                             tdo,
  output logic                             tdo_oe,
  input  wire logic [`SBT_PIN_CELLS-1:0]   pin_ring_in,
  output logic      [`SBT_PIN_CELLS-1:0]   ring_drive,
  output logic                             extest_sel,
  output logic                             q_force_hiz,
  output logic      [`SBT_IR_W-1:0]        cur_instr
);
  import sbt_pkg::*;

  localparam logic [`SBT_ID_W-1:0] ID_VALUE =
    {`SBT_ID_REV_VAL, `SBT_ID_DEV_VAL, `SBT_ID_MFR_VAL, 1'h1};

  // ==========================================================
  // synchronisers and test clock edges
  logic [2:0]                    s1_q;
  logic [2:0]                    s2_q;
  logic                          tck_d3_q;
  logic [`SBT_PIN_CELLS-1:0]     pin1_q;
  logic [`SBT_PIN_CELLS-1:0]     pin2_q;
  logic                          rise;
  logic                          fall;
  logic                          tms_s;
  logic                          tdi_s;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q     <= 3'h0;
      s2_q     <= 3'h0;
      tck_d3_q <= 1'h0;
    end else begin
      s1_q     <= {tck, tms, tdi};
      s2_q     <= s1_q;
      tck_d3_q <= s2_q[2];
    end
  end

  // pin snapshot may be caught mid-transition; only the chain is affected
  always_ff @(posedge mclk) begin
    pin1_q <= pin_ring_in;
    pin2_q <= pin1_q;
  end

  assign rise  = s2_q[2] & ~tck_d3_q;
  assign fall  = ~s2_q[2] & tck_d3_q;
  assign tms_s = s2_q[1];
  assign tdi_s = s2_q[0];

  // ==========================================================
  // controller
  sbt_state_t st;

  sbt_tap_fsm u_fsm (
    .mclk    (mclk),
    .rst     (rst),
    .adv     (rise),
    .tms     (tms_s),
    .state_q (st)
  );

  function automatic logic uses_chain(input logic [`SBT_IR_W-1:0] op);
    uses_chain = (op == `SBT_OP_EXTEST) || (op == `SBT_OP_SAMPLEZ) ||
                 (op == `SBT_OP_SAMPLE);
  endfunction

  // ==========================================================
  // instruction register
  logic [`SBT_IR_W-1:0] ir_q;
  logic [`SBT_IR_W-1:0] ir_sh_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ir_sh_q <= `SBT_IR_CAPTURE;
    end else if (rise) begin
      case (st)
        SBT_CAP_IR: ir_sh_q <= `SBT_IR_CAPTURE;
        SBT_SH_IR:  ir_sh_q <= {tdi_s, ir_sh_q[`SBT_IR_W-1:1]};
        default:    ir_sh_q <= ir_sh_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ir_q <= `SBT_OP_IDCODE;
    end else if (st == SBT_TLR) begin
      ir_q <= `SBT_OP_IDCODE;
    end else if (rise && st == SBT_UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  // ==========================================================
  // data registers; reserved codes fall back to bypass
  logic [`SBT_ID_W-1:0]    id_sh_q;
  logic [`SBT_BSR_LEN-1:0] bsr_sh_q;
  logic [`SBT_BSR_LEN-1:0] bsr_upd_q;
  logic                    byp_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      id_sh_q  <= ID_VALUE;
      bsr_sh_q <= '0;
      byp_q    <= `SBT_BYP_RST;
    end else if (rise && st == SBT_CAP_DR) begin
      if (ir_q == `SBT_OP_IDCODE) begin
        id_sh_q <= ID_VALUE;
      end else if (uses_chain(ir_q)) begin
        bsr_sh_q <= {bsr_upd_q[`SBT_OE_CELL], pin2_q};
      end else begin
        byp_q <= `SBT_BYP_RST;
      end
    end else if (rise && st == SBT_SH_DR) begin
      if (ir_q == `SBT_OP_IDCODE) begin
        id_sh_q <= {tdi_s, id_sh_q[`SBT_ID_W-1:1]};
      end else if (uses_chain(ir_q)) begin
        bsr_sh_q <= {tdi_s, bsr_sh_q[`SBT_BSR_LEN-1:1]};
      end else begin
        byp_q <= tdi_s;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || st == SBT_TLR) begin
      bsr_upd_q <= '0;
    end else if (rise && st == SBT_UPD_DR && uses_chain(ir_q)) begin
      bsr_upd_q <= bsr_sh_q;
    end
  end

  // ==========================================================
  // pin side controls
  assign ring_drive  = bsr_upd_q[`SBT_PIN_CELLS-1:0];
  assign extest_sel  = (ir_q == `SBT_OP_EXTEST);
  assign q_force_hiz = (ir_q == `SBT_OP_SAMPLEZ) ||
                       (extest_sel && !bsr_upd_q[`SBT_OE_CELL]);
  assign cur_instr   = ir_q;

  // ==========================================================
  // serial output, moved only on the test clock fall
  logic tdo_bit;

  always_comb begin
    if (st == SBT_SH_IR) begin
      tdo_bit = ir_sh_q[0];
    end else if (ir_q == `SBT_OP_IDCODE) begin
      tdo_bit = id_sh_q[0];
    end else if (uses_chain(ir_q)) begin
      tdo_bit = bsr_sh_q[0];
    end else begin
      tdo_bit = byp_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tdo    <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (fall) begin
      tdo    <= tdo_bit;
      tdo_oe <= (st == SBT_SH_IR) || (st == SBT_SH_DR);
    end
  end

  // ==========================================================
  // checks
  logic [2:0] tms_run_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tms_run_q <= 3'h0;
    end else if (rise) begin
      tms_run_q <= !tms_s ? 3'h0 : (tms_run_q == `SBT_TMS_RESET_N) ? tms_run_q
                                                                   : tms_run_q + 3'h1;
    end
  end

  property p_tms_reset;
    @(posedge mclk) disable iff (rst) (tms_run_q == `SBT_TMS_RESET_N) |-> st == SBT_TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("five tms highs not in reset");

  property p_tlr_idcode;
    @(posedge mclk) disable iff (rst) st == SBT_TLR |=> ir_q == `SBT_OP_IDCODE;
  endproperty
  a_tlr_idcode: assert property (p_tlr_idcode) else $error("reset lost id code");

  property p_ir_capture;
    @(posedge mclk) disable iff (rst) rise && st == SBT_CAP_IR |=> ir_sh_q[1:0] == 2'h1;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("ir capture not 01");

  property p_id_capture;
    @(posedge mclk) disable iff (rst)
      rise && st == SBT_CAP_DR && ir_q == `SBT_OP_IDCODE |=> id_sh_q[0] && id_sh_q == ID_VALUE;
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id capture wrong");

  property p_bsr_capture;
    @(posedge mclk) disable iff (rst)
      rise && st == SBT_CAP_DR && uses_chain(ir_q)
      |=> bsr_sh_q[`SBT_PIN_CELLS-1:0] == $past(pin2_q);
  endproperty
  a_bsr_capture: assert property (p_bsr_capture) else $error("pin capture wrong");

  property p_bypass_cap;
    @(posedge mclk) disable iff (rst)
      rise && st == SBT_CAP_DR && ir_q == `SBT_OP_BYPASS |=> !byp_q;
  endproperty
  a_bypass_cap: assert property (p_bypass_cap) else $error("bypass not cleared");

  property p_samplez_hiz;
    @(posedge mclk) disable iff (rst) ir_q == `SBT_OP_SAMPLEZ |-> q_force_hiz && !extest_sel;
  endproperty
  a_samplez_hiz: assert property (p_samplez_hiz) else $error("sample z not high-Z");

  property p_extest_gate;
    @(posedge mclk) disable iff (rst)
      ir_q == `SBT_OP_EXTEST |-> q_force_hiz == !bsr_upd_q[`SBT_OE_CELL];
  endproperty
  a_extest_gate: assert property (p_extest_gate) else $error("oe cell gate wrong");

  property p_sample_quiet;
    @(posedge mclk) disable iff (rst)
      ir_q == `SBT_OP_SAMPLE |-> !extest_sel && !q_force_hiz;
  endproperty
  a_sample_quiet: assert property (p_sample_quiet) else $error("sample disturbs pins");

  property p_tdo_on_fall;
    @(posedge mclk) disable iff (rst) !fall |=> $stable(tdo) && $stable(tdo_oe);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off fall");

endmodule // sbt_tap

// File: rtl/sbt_defs.svh
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

// ==========================================================
// register sizes
`define SBT_IR_W        3
`define SBT_ID_W        32
`define SBT_BSR_LEN     109
`define SBT_PIN_CELLS   108
`define SBT_OE_CELL     108

// ==========================================================
// instruction codes
`define SBT_OP_EXTEST   3'h0
`define SBT_OP_IDCODE   3'h1
`define SBT_OP_SAMPLEZ  3'h2
`define SBT_OP_RSVD3    3'h3
`define SBT_OP_SAMPLE   3'h4
`define SBT_OP_RSVD5    3'h5
`define SBT_OP_RSVD6    3'h6
`define SBT_OP_BYPASS   3'h7
`define SBT_IR_CAPTURE  3'h1

// ==========================================================
// identification value fields
`define SBT_ID_REV_HI   31
`define SBT_ID_REV_LO   29
`define SBT_ID_DEV_HI   28
`define SBT_ID_DEV_LO   12
`define SBT_ID_MFR_HI   11
`define SBT_ID_MFR_LO   1
`define SBT_ID_PRESENT  0
// arbitrary neutral values
`define SBT_ID_REV_VAL  3'h1
`define SBT_ID_DEV_VAL  17'h0ABCD
`define SBT_ID_MFR_VAL  11'h2A5

// ==========================================================
// reset values
`define SBT_BYP_RST     1'h0
`define SBT_OE_CELL_RST 1'h0
`define SBT_TMS_RESET_N 3'h5

`endif

// File: rtl/sbt_pkg.sv
package sbt_pkg;
  typedef enum logic [3:0] {
    SBT_TLR, SBT_RTI,
    SBT_SEL_DR, SBT_CAP_DR, SBT_SH_DR, SBT_EX1_DR, SBT_PA_DR, SBT_EX2_DR, SBT_UPD_DR,
    SBT_SEL_IR, SBT_CAP_IR, SBT_SH_IR, SBT_EX1_IR, SBT_PA_IR, SBT_EX2_IR, SBT_UPD_IR
  } sbt_state_t;
endpackage

// File: rtl/sbt_tap_fsm.sv
`timescale 1ns/1ps
module sbt_tap_fsm (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               adv,
  input  wire logic               tms,
  output sbt_pkg::sbt_state_t     state_q
);
  import sbt_pkg::*;

  sbt_state_t state_d;

  // ==========================================================
  // next state, taken only on a test clock rise
  always_comb begin
    case (state_q)
      SBT_TLR:    state_d = tms ? SBT_TLR    : SBT_RTI;
      SBT_RTI:    state_d = tms ? SBT_SEL_DR : SBT_RTI;
      SBT_SEL_DR: state_d = tms ? SBT_SEL_IR : SBT_CAP_DR;
      SBT_CAP_DR: state_d = tms ? SBT_EX1_DR : SBT_SH_DR;
      SBT_SH_DR:  state_d = tms ? SBT_EX1_DR : SBT_SH_DR;
      SBT_EX1_DR: state_d = tms ? SBT_UPD_DR : SBT_PA_DR;
      SBT_PA_DR:  state_d = tms ? SBT_EX2_DR : SBT_PA_DR;
      SBT_EX2_DR: state_d = tms ? SBT_UPD_DR : SBT_SH_DR;
      SBT_UPD_DR: state_d = tms ? SBT_SEL_DR : SBT_RTI;
      SBT_SEL_IR: state_d = tms ? SBT_TLR    : SBT_CAP_IR;
      SBT_CAP_IR: state_d = tms ? SBT_EX1_IR : SBT_SH_IR;
      SBT_SH_IR:  state_d = tms ? SBT_EX1_IR : SBT_SH_IR;
      SBT_EX1_IR: state_d = tms ? SBT_UPD_IR : SBT_PA_IR;
      SBT_PA_IR:  state_d = tms ? SBT_EX2_IR : SBT_PA_IR;
      SBT_EX2_IR: state_d = tms ? SBT_UPD_IR : SBT_SH_IR;
      SBT_UPD_IR: state_d = tms ? SBT_SEL_DR : SBT_RTI;
      default:    state_d = SBT_TLR;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= SBT_TLR;
    end else if (adv) begin
      state_q <= state_d;
    end
  end
endmodule // sbt_tap_fsm

// File: sim/sbt_ctl_model.sv
`timescale 1ns/1ps
// ==========================================================
// board test controller: drives the test link, reads tdo
module sbt_ctl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // tck stands low between frames; inputs move at the fall
  task automatic clk(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5;
    o   = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask

  // tdi toggles when not shifting so stale data never looks valid
  task automatic nav(input logic m);
    logic o;
    clk(m, ~tdi, o);
  endtask

  task automatic tap_reset();
    repeat (5) nav(1'b1);
    nav(1'b0);
  endtask

  // from idle through capture, n shifts, update, back to idle
  task automatic shift(input logic ir, input int n, input logic [108:0] din,
                       output logic [108:0] dout);
    logic o;
    dout = '0;
    nav(1'b1);
    if (ir) begin
      nav(1'b1);
    end
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], o);
      dout[i] = o;
    end
    nav(1'b1);
    nav(1'b0);
  endtask
endmodule // sbt_ctl_model

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "sbt_defs.svh"
module testbench;
  localparam logic [108:0] PA = {1'b1, {9{12'hA5C}}};
  localparam logic [108:0] PB = {1'b1, {9{12'h3E1}}};
  logic         mclk;
  logic         rst;
  wire          tck;
  wire          tms;
  wire          tdi;
  logic         tdo;
  logic         tdo_oe;
  logic [107:0] pin_ring_in;
  logic [107:0] ring_drive;
  logic         extest_sel;
  logic         q_force_hiz;
  logic [2:0]   cur_instr;
  logic [108:0] v;
  int           n_mismatch;
  int           n_compared;

  // ==========================================================
  // instances
  sbt_tap u_dut (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_ring_in(pin_ring_in), .ring_drive(ring_drive),
    .extest_sel(extest_sel), .q_force_hiz(q_force_hiz), .cur_instr(cur_instr));
  // released tdo shows the inverse so a stale bit cannot match
  sbt_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : ~tdo));

  always #5 mclk = ~mclk;

  // ==========================================================
  // helpers
  task automatic chk(input logic [108:0] seen, input logic [108:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic pins(input logic [107:0] p);
    @(posedge mclk);
    #1 pin_ring_in = p;
  endtask

  // only codes 000, 001, 010, 100 and 111 are ever loaded
  task automatic ld(input logic [2:0] c);
    u_ctl.shift(1'b1, 3, {106'h0, c}, v);
    chk(109'(v[1:0]), 109'(2'b01));
    chk(109'(cur_instr), 109'(c));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_state();
    chk(109'(cur_instr), 109'(`SBT_OP_IDCODE));
    chk(109'(tdo_oe), 109'(1'b0));
    chk(109'({extest_sel, q_force_hiz}), 109'(2'b00));
    u_ctl.tap_reset();
  endtask

  task automatic t_idcode();
    u_ctl.shift(1'b0, 32, '0, v);
    chk(109'(v[31:29]), 109'(`SBT_ID_REV_VAL));
    chk(109'(v[28:12]), 109'(`SBT_ID_DEV_VAL));
    chk(109'(v[11:1]), 109'(`SBT_ID_MFR_VAL));
    chk(109'(v[0]), 109'(1'b1));
    chk(109'(q_force_hiz), 109'(1'b0));
  endtask

  task automatic t_bypass();
    ld(`SBT_OP_BYPASS);
    u_ctl.shift(1'b0, 8, 109'hB4, v);
    chk(109'(v[7:0]), 109'(8'h68));
  endtask

  task automatic t_sample();
    pins(PA[107:0]);
    ld(`SBT_OP_SAMPLE);
    u_ctl.shift(1'b0, 109, PB, v);
    chk(v, {1'b0, PA[107:0]});
    chk(109'(ring_drive), 109'(PB[107:0]));
    chk(109'({extest_sel, q_force_hiz}), 109'(2'b00));
  endtask

  task automatic t_extest();
    ld(`SBT_OP_EXTEST);
    chk(109'({extest_sel, q_force_hiz}), 109'(2'b10));
    pins(PB[107:0]);
    u_ctl.shift(1'b0, 109, {1'b0, PA[107:0]}, v);
    chk(v, PB);
    chk(109'(q_force_hiz), 109'(1'b1));
    chk(109'(ring_drive), 109'(PA[107:0]));
  endtask

  task automatic t_samplez();
    ld(`SBT_OP_SAMPLEZ);
    chk(109'({extest_sel, q_force_hiz}), 109'(2'b01));
    pins(~PA[107:0]);
    u_ctl.shift(1'b0, 109, PA, v);
    chk(v, {1'b0, ~PA[107:0]});
  endtask

  task automatic t_tap_reset();
    u_ctl.tap_reset();
    chk(109'(cur_instr), 109'(`SBT_OP_IDCODE));
    chk(109'(q_force_hiz), 109'(1'b0));
    ld(`SBT_OP_EXTEST);
    chk(109'(q_force_hiz), 109'(1'b1));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mclk        = 1'b0;
    rst         = 1'b1;
    pin_ring_in = '0;
    n_mismatch  = 0;
    n_compared  = 0;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    t_reset_state();
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_samplez();
    t_tap_reset();
    end_of_test();
  end

  // run needs about 56 us of link traffic
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule // testbench
